/* File: dv/idt_decode_asserts.sv */
// Purpose: Port-level checks of the instruction decoder
// Assumes: Opcodes and cycle counts from the constants header
// Notes:   Bound to every idt_decode instance
`default_nettype none
`include "idt_consts.svh"
module idt_decode_asserts (
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RST_N,
  // Observed outputs
  input wire logic              FETCH_READY,
  input wire logic              REDIRECT,
  input wire logic              ISSUE_VALID,
  input wire logic              ISSUE_NOP,
  input wire logic [47:0]       ISSUE_INSTR,
  input wire logic [7:0]        ISSUE_OPCODE,
  input wire idt_pkg::idt_fmt_t ISSUE_FORMAT,
  input wire logic [1:0]        ISSUE_CYCLES
);
  timeunit 1ns;
  timeprecision 1ps;
  import idt_pkg::*;
  logic       real_iss;
  logic       dw_op;
  logic [7:0] op;
  default clocking dcb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Fillers are excluded so checks tie to the instruction itself
  assign real_iss = ISSUE_VALID && !ISSUE_NOP;
  assign op = ISSUE_OPCODE;
  assign dw_op = op inside {`IDT_OP_CALL_DW, `IDT_OP_GOTO_DW, `IDT_OP_MOVE_DW};
  ////////////////////////////////////////////////////////////////////////
  a_jump_fill: assert property (real_iss && op == `IDT_OP_JUMP |->
    REDIRECT && ISSUE_CYCLES == 2'd2 ##1 ISSUE_VALID && ISSUE_NOP) else $error("jump without one filler");
  a_return_fill: assert property (real_iss && op inside {`IDT_OP_RETURN, `IDT_OP_INT_RET} |->
    REDIRECT && ISSUE_CYCLES == 2'd3 ##1 (ISSUE_VALID && ISSUE_NOP) [*2]) else $error("return without two fillers");
  a_redirect_cause: assert property (REDIRECT |->
    real_iss && ISSUE_FORMAT == FMT_CTRL && ISSUE_CYCLES != 2'd1) else $error("redirect without control op");
  a_plain_single: assert property (real_iss && !dw_op && ISSUE_FORMAT != FMT_CTRL && ISSUE_FORMAT != FMT_NONE |->
    ISSUE_CYCLES == 2'd1 && !REDIRECT ##1 !(ISSUE_VALID && ISSUE_NOP)) else $error("data op not single cycle");
  a_table_stall: assert property (real_iss && op == `IDT_OP_TABLE |->
    !FETCH_READY && ISSUE_CYCLES == 2'd2 ##1 ISSUE_VALID && ISSUE_NOP && FETCH_READY) else $error("table fill wrong");
  a_ready_cause: assert property ($fell(FETCH_READY) |->
    real_iss && op == `IDT_OP_TABLE || $past(REDIRECT)) else $error("fetch refused outside table fill");
  a_dw_join: assert property (real_iss && dw_op |->
    ISSUE_CYCLES == 2'd2 && ISSUE_INSTR[23:16] == 8'h00) else $error("double word not joined");
  a_zero_nop: assert property (ISSUE_VALID && op == 8'h00 |-> ISSUE_NOP && !REDIRECT)
    else $error("zero opcode not a no-op");
  a_single_pad: assert property (real_iss && !dw_op |-> ISSUE_INSTR[23:0] == 24'h0)
    else $error("single word not padded");
  // Main scenarios reached
  c_jump: cover property (real_iss && REDIRECT);
  c_table: cover property (!FETCH_READY);
  c_dw: cover property (real_iss && dw_op);
endmodule
bind idt_decode idt_decode_asserts idt_decode_asserts_i (
  .CLK(CLK), .RST_N(RST_N), .FETCH_READY(FETCH_READY), .REDIRECT(REDIRECT), .ISSUE_VALID(ISSUE_VALID),
  .ISSUE_NOP(ISSUE_NOP), .ISSUE_INSTR(ISSUE_INSTR), .ISSUE_OPCODE(ISSUE_OPCODE), .ISSUE_FORMAT(ISSUE_FORMAT),
  .ISSUE_CYCLES(ISSUE_CYCLES));
`default_nettype wire

/* File: dv/idt_pmem_model.sv */
// Purpose: Program memory offering words to the decoder
// Assumes: 32 words, loaded by the bench before each run
// Notes:   Follows REDIRECT at once; SLOW idles one cycle per word
`default_nettype none
module idt_pmem_model (
  // Clock
  input wire logic          CLK,
  // Controls
  input wire logic          SLOW,
  input wire logic          FETCH_READY,
  input wire logic          REDIRECT,
  input wire logic [22:0]   TARGET,
  // Word offer
  output logic              FETCH_VALID,
  output logic [23:0]       FETCH_WORD,
  output logic              COND_TRUE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem [0:31];
  logic        cnd [0:31];
  int          pa = 0;
  int          stop = 0;
  logic        gap = 1'b0;
  initial
  begin
    FETCH_VALID = 1'b0;
    FETCH_WORD = 24'h0;
    COND_TRUE = 1'b0;
  end
  task automatic load(input int a, input logic [23:0] w, input logic c);
    mem[a] = w;
    cnd[a] = c;
  endtask
  task automatic run(input int n);
    pa = 0;
    stop = n;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // A redirect wins over the step, so the fetched-ahead word is lost
  always @(posedge CLK)
  begin
    if (REDIRECT)
      pa <= int'(TARGET[4:0]);
    else if (FETCH_VALID && FETCH_READY)
      pa <= pa + 1;
    gap <= SLOW && FETCH_VALID && FETCH_READY;
  end
  // Held until taken; idle lines toggle so stale data never looks valid
  always @(negedge CLK)
  begin
    if (pa < stop && !gap)
    begin
      FETCH_VALID <= 1'b1;
      FETCH_WORD <= mem[pa];
      COND_TRUE <= cnd[pa];
    end
    else
    begin
      FETCH_VALID <= 1'b0;
      FETCH_WORD <= ~FETCH_WORD;
      COND_TRUE <= ~COND_TRUE;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench of the instruction decoder
// Assumes: Opcode map of the constants header
// Notes:   Inputs change on the falling edge
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import idt_pkg::*;
  logic        clk, rst_n, slow, fetch_valid, fetch_ready, cond_true, redirect, iss_valid, iss_nop;
  logic        op_byte, op_dst_valid, op_dest_file, op_bit_ind;
  logic [23:0] fetch_word;
  logic [47:0] iss_instr;
  logic [7:0]  iss_op;
  idt_fmt_t    iss_fmt;
  logic [1:0]  iss_cyc, op_src_mode, op_dst_mode, op_tbl_mode;
  logic [3:0]  op_base, op_src, op_dst, op_bit_pos;
  logic [12:0] op_file_addr;
  logic [15:0] op_lit;
  logic [22:0] op_prog_addr;
  int          miscompares, n_compared, ld_n;
  idt_decode idt_decode_i (.CLK(clk), .RST_N(rst_n), .FETCH_VALID(fetch_valid), .FETCH_WORD(fetch_word),
    .FETCH_READY(fetch_ready), .COND_TRUE(cond_true), .REDIRECT(redirect), .ISSUE_VALID(iss_valid),
    .ISSUE_NOP(iss_nop), .ISSUE_INSTR(iss_instr), .ISSUE_OPCODE(iss_op), .ISSUE_FORMAT(iss_fmt),
    .ISSUE_CYCLES(iss_cyc), .OP_BYTE(op_byte), .OP_BASE_REG(op_base), .OP_SRC_REG(op_src),
    .OP_SRC_MODE(op_src_mode), .OP_DST_REG(op_dst), .OP_DST_MODE(op_dst_mode), .OP_DST_VALID(op_dst_valid),
    .OP_FILE_ADDR(op_file_addr), .OP_DEST_FILE(op_dest_file), .OP_BIT_POS(op_bit_pos),
    .OP_BIT_INDIRECT(op_bit_ind), .OP_LITERAL(op_lit), .OP_PROG_ADDR(op_prog_addr), .OP_TBL_MODE(op_tbl_mode));
  idt_pmem_model idt_pmem_model_i (.CLK(clk), .SLOW(slow), .FETCH_READY(fetch_ready), .REDIRECT(redirect),
    .TARGET(op_prog_addr), .FETCH_VALID(fetch_valid), .FETCH_WORD(fetch_word), .COND_TRUE(cond_true));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for an issue, optionally skipping fillers
  task automatic wait_iss(input bit real_only);
    for (int k = 0; k < 40; k++)
    begin
      @(negedge clk);
      if (iss_valid === 1'b1 && (!real_only || iss_nop === 1'b0)) return;
    end
    miscompares++;
    $display("mismatch at %0t: no instruction issued", $time);
    end_sim;
  endtask
  task automatic iss(input logic [7:0] op, input logic [1:0] cyc, input logic rd);
    wait_iss(1'b0);
    chk(48'({iss_nop, redirect, iss_op, iss_cyc}), 48'({1'b0, rd, op, cyc}), "issue");
  endtask
  task automatic filler;
    wait_iss(1'b0);
    chk(48'({iss_nop, redirect}), 48'h2, "filler");
  endtask
  task automatic put(input logic [23:0] w, input logic c = 1'b0);
    idt_pmem_model_i.load(ld_n, w, c);
    ld_n++;
  endtask
  // Started on a rising edge, before the next offer
  task automatic start(input int n);
    @(posedge clk);
    idt_pmem_model_i.run(n);
  endtask
  task automatic settle;
    int q;
    q = 0;
    for (int k = 0; k < 60 && q < 3; k++)
    begin
      @(negedge clk);
      q = (fetch_valid === 1'b0 && iss_valid === 1'b0) ? q + 1 : 0;
    end
    if (q < 3)
    begin
      miscompares++;
      $display("mismatch at %0t: decoder never idle", $time);
      end_sim;
    end
    ld_n = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Register and file operand formats, back to back
  task automatic t_work_file;
    put(24'h41A953);
    put(24'h501234);
    put(24'h503234);
    start(ld_n);
    iss(8'h41, 2'd1, 1'b0);
    chk(48'({iss_fmt, op_byte, op_base, op_src_mode, op_src, op_dst_mode, op_dst, op_dst_valid}), 48'({FMT_WORK, 17'h1A953, 1'b1}), "work");
    iss(8'h50, 2'd1, 1'b0);
    chk(48'({iss_fmt, op_file_addr, op_dest_file, op_dst_valid, op_dst}), 48'({FMT_FILE, 13'h1234, 6'h10}), "file w0");
    iss(8'h50, 2'd1, 1'b0);
    chk(48'({op_file_addr, op_dest_file, op_dst_valid}), 48'({13'h1234, 2'b10}), "file f");
    settle;
  endtask
  // Bit and literal operand formats
  task automatic t_bit_lit;
    put(24'h600279);
    put(24'h60D556);
    put(24'h70ABCD);
    put(24'h803567);
    put(24'h803D67);
    start(ld_n);
    iss(8'h60, 2'd1, 1'b0);
    chk(48'({iss_fmt, op_bit_ind, op_src_mode, op_src, op_bit_pos}), 48'({FMT_BIT, 11'h279}), "bit lit");
    iss(8'h60, 2'd1, 1'b0);
    chk(48'({op_bit_ind, op_base, op_bit_pos, op_file_addr}), 48'({1'b1, 4'h6, 4'h0, 13'h155}), "bit ind");
    iss(8'h70, 2'd1, 1'b0);
    chk(48'({iss_fmt, op_lit, op_dst, op_dst_valid}), 48'({FMT_LITMOV, 16'h0ABC, 4'hD, 1'b1}), "litmov");
    iss(8'h80, 2'd1, 1'b0);
    chk(48'({iss_fmt, op_base, op_lit, op_dst_mode, op_dst, op_dst_valid}), 48'({FMT_LITALU, 4'h3, 16'h15, 7'h4F}), "litalu");
    iss(8'h80, 2'd1, 1'b0);
    chk(48'({op_lit, op_dst_valid}), 48'({16'h15, 1'b0}), "litalu same");
    settle;
  endtask
  // Every redirecting op, a conditional branch taken and not taken
  task automatic t_ctrl;
    logic [7:0] ops [6] = '{8'h01, 8'h05, 8'h06, 8'h07, 8'h03, 8'h03};
    logic [1:0] cyc [6] = '{2'd2, 2'd2, 2'd3, 2'd3, 2'd2, 2'd1};
    for (int i = 0; i < 6; i++)
    begin
      put({ops[i], 16'h0004}, i == 4);
      for (int a = 1; a < 8; a++) put(24'h400000 | 24'(a));
      start(cyc[i] == 2'd1 ? 2 : 8);
      iss(ops[i], cyc[i], cyc[i] != 2'd1);
      if (i == 0) chk(48'(op_prog_addr), 48'h4, "jump target");
      for (int n = 1; n < cyc[i]; n++) filler;
      wait_iss(1'b0);
      chk(iss_instr, {cyc[i] == 2'd1 ? 24'h400001 : 24'h400004, 24'h0}, "after branch");
      settle;
    end
  endtask
  // Table access stalls the fetch in its own issue cycle, ahead of its filler
  task automatic t_table;
    put(24'h090003);
    put(24'h400009);
    start(ld_n);
    iss(8'h09, 2'd2, 1'b0);
    chk(48'({fetch_ready, op_tbl_mode}), 48'h3, "table fill");
    filler;
    iss(8'h40, 2'd1, 1'b0);
    settle;
  endtask
  // Double words from a slow memory, a lone second word between them
  task automatic t_dw;
    slow = 1'b1;
    put(24'h021202);
    put(24'h000055);
    put(24'h080000);
    put(24'h00BEEF);
    put(24'h001111);
    put(24'h040007);
    put(24'h000000);
    put(24'h400007);
    start(ld_n);
    wait_iss(1'b1);
    chk(iss_instr, {24'h021202, 24'h000055}, "call joined");
    chk(48'({op_prog_addr, iss_cyc}), 48'({23'h551202, 2'd2}), "call addr");
    wait_iss(1'b1);
    chk(48'({iss_op, iss_cyc, op_lit}), 48'({8'h08, 2'd2, 16'hBEEF}), "dw move");
    wait_iss(1'b1);
    chk(iss_instr, {24'h040007, 24'h0}, "goto after lone word");
    wait_iss(1'b1);
    chk(iss_instr, {24'h400007, 24'h0}, "after goto");
    settle;
    slow = 1'b0;
  endtask
  // Taken skips over a single word and over a double word
  task automatic t_skip;
    put(24'h0A0000, 1'b1);
    put(24'h400001);
    put(24'h400002);
    put(24'h0A0000, 1'b1);
    put(24'h040006);
    put(24'h000000);
    put(24'h400003);
    start(ld_n);
    iss(8'h0A, 2'd2, 1'b0);
    filler;
    wait_iss(1'b0);
    chk(iss_instr, {24'h400002, 24'h0}, "after skip");
    iss(8'h0A, 2'd2, 1'b0);
    filler;
    filler;
    wait_iss(1'b0);
    chk(iss_instr, {24'h400003, 24'h0}, "after dw skip");
    settle;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  always #10 clk = ~clk;
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    slow = 1'b0;
    miscompares = 0;
    n_compared = 0;
    ld_n = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_work_file;
    t_bit_lit;
    t_ctrl;
    t_table;
    t_dw;
    t_skip;
    end_sim;
  end
endmodule
`default_nettype wire

/* File: pkg/idt_consts.svh */
// Purpose: Opcodes, field positions and cycle counts of the decoder
// Assumes: 24-bit program words, 8-bit opcode in the top bits
// Notes:   Definitions only
`ifndef IDT_CONSTS_SVH
`define IDT_CONSTS_SVH

// Word geometry
`define IDT_WORD_W      24
`define IDT_OPC_LSB     16
`define IDT_BYTE_BIT    16
// Opcodes of the no-op, control and double-word instructions
`define IDT_OP_NOP      8'h00
`define IDT_OP_JUMP     8'h01
`define IDT_OP_CALL_DW  8'h02
`define IDT_OP_BR_COND  8'h03
`define IDT_OP_GOTO_DW  8'h04
`define IDT_OP_IND_JMP  8'h05
`define IDT_OP_RETURN   8'h06
`define IDT_OP_INT_RET  8'h07
`define IDT_OP_MOVE_DW  8'h08
`define IDT_OP_TABLE    8'h09
`define IDT_OP_SKIP     8'h0A
// Upper opcode nibble of the data classes
`define IDT_GRP_WORK    4'h4
`define IDT_GRP_FILE    4'h5
`define IDT_GRP_BIT     4'h6
`define IDT_GRP_LITMOV  4'h7
`define IDT_GRP_LITALU  4'h8
// Operand field positions (least significant bit)
`define IDT_BASE_LSB    12
`define IDT_SMODE_LSB   10
`define IDT_SREG_LSB    6
`define IDT_DMODE_LSB   4
`define IDT_DREG_LSB    0
`define IDT_FADDR_LSB   0
`define IDT_FDEST_BIT   13
`define IDT_BIND_BIT    15
`define IDT_BFILE_BIT   14
`define IDT_BOPND_LSB   4
`define IDT_BPOS_LSB    0
`define IDT_LMOV_LSB    4
`define IDT_LALU_LSB    6
`define IDT_LSAME_BIT   11
`define IDT_TMODE_LSB   0
// Instruction cycles per kind
`define IDT_CYC_ONE     2'd1
`define IDT_CYC_JUMP    2'd2
`define IDT_CYC_IND     2'd2
`define IDT_CYC_TABLE   2'd2
`define IDT_CYC_RET     2'd3
`define IDT_CYC_COND    2'd2
`define IDT_CYC_DW      2'd2

`endif

/* File: pkg/idt_pkg.sv */
// Purpose: Types shared by the instruction decoder files
// Assumes: Nothing beyond the constants header
// Notes:   Codes of the enums are internal only
`default_nettype none
package idt_pkg;
  // Operand format of a decoded instruction
  typedef enum logic [2:0] {
    FMT_NONE   = 3'b000,
    FMT_WORK   = 3'b001,
    FMT_FILE   = 3'b010,
    FMT_BIT    = 3'b011,
    FMT_LITMOV = 3'b100,
    FMT_LITALU = 3'b101,
    FMT_CTRL   = 3'b110
  } idt_fmt_t;
  // Timing kind of a decoded instruction
  typedef enum logic [2:0] {
    CK_NONE = 3'b000,
    CK_JUMP = 3'b001,
    CK_COND = 3'b010,
    CK_IND  = 3'b011,
    CK_RET  = 3'b100,
    CK_TBL  = 3'b101,
    CK_SKIP = 3'b110,
    CK_DW   = 3'b111
  } idt_ctl_t;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_SECOND = 3'b001,
    ST_FILL   = 3'b010,
    ST_SKIP   = 3'b011,
    ST_SKIP2  = 3'b100
  } idt_state_t;
endpackage
`default_nettype wire

/* File: rtl/idt_classify.sv */
// Purpose: Sorts an opcode into format, timing kind and cycle count
// Assumes: Purely combinational, opcode from a fetched word
// Notes:   Unknown opcodes act as one-cycle instructions
`default_nettype none
`include "idt_consts.svh"
module idt_classify (
  // Opcode in
  input  wire logic [7:0]        opcode,
  // Class out
  output idt_pkg::idt_fmt_t      fmt,
  output idt_pkg::idt_ctl_t      ctl,
  output logic                   dbl,
  output logic [1:0]             cycles
);
  import idt_pkg::*;

  // Control opcodes first, then data groups by upper nibble
  always_comb
  begin
    fmt    = FMT_NONE;
    ctl    = CK_NONE;
    dbl    = 1'b0;
    cycles = `IDT_CYC_ONE;
    case (opcode)
      `IDT_OP_NOP:
      begin
        fmt = FMT_NONE;
      end
      `IDT_OP_JUMP:
      begin
        fmt    = FMT_CTRL;
        ctl    = CK_JUMP;
        cycles = `IDT_CYC_JUMP;
      end
      `IDT_OP_BR_COND:
      begin
        fmt    = FMT_CTRL;
        ctl    = CK_COND;
        cycles = `IDT_CYC_ONE;
      end
      `IDT_OP_IND_JMP:
      begin
        fmt    = FMT_CTRL;
        ctl    = CK_IND;
        cycles = `IDT_CYC_IND;
      end
      `IDT_OP_RETURN, `IDT_OP_INT_RET:
      begin
        fmt    = FMT_CTRL;
        ctl    = CK_RET;
        cycles = `IDT_CYC_RET;
      end
      `IDT_OP_TABLE:
      begin
        fmt    = FMT_CTRL;
        ctl    = CK_TBL;
        cycles = `IDT_CYC_TABLE;
      end
      `IDT_OP_SKIP:
      begin
        fmt = FMT_NONE;
        ctl = CK_SKIP;
      end
      // Exactly three opcodes span two locations
      `IDT_OP_CALL_DW, `IDT_OP_GOTO_DW, `IDT_OP_MOVE_DW:
      begin
        fmt    = (opcode == `IDT_OP_MOVE_DW) ? FMT_LITMOV : FMT_CTRL;
        ctl    = CK_DW;
        dbl    = 1'b1;
        cycles = `IDT_CYC_DW;
      end
      default:
      begin
        case (opcode[7:4])
          `IDT_GRP_WORK:   fmt = FMT_WORK;
          `IDT_GRP_FILE:   fmt = FMT_FILE;
          `IDT_GRP_BIT:    fmt = FMT_BIT;
          `IDT_GRP_LITMOV: fmt = FMT_LITMOV;
          `IDT_GRP_LITALU: fmt = FMT_LITALU;
          default:         fmt = FMT_NONE;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: rtl/idt_decode.sv */
// Purpose: Instruction word decode and cycle sequencing of the core
// Assumes: One word offered per cycle, condition resolved with the word
// Notes:   Filler cycles appear as issued no-operations
`default_nettype none
`include "idt_consts.svh"
////////////////////////////////////////////////////////////////////////
module idt_decode (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // Program memory words
  input  wire logic              FETCH_VALID,
  input  wire logic [23:0]       FETCH_WORD,
  output logic                   FETCH_READY,
  // Condition of the offered word
  input  wire logic              COND_TRUE,
  // Fetch redirection
  output logic                   REDIRECT,
  // Issued instruction
  output logic                   ISSUE_VALID,
  output logic                   ISSUE_NOP,
  output logic [47:0]            ISSUE_INSTR,
  output logic [7:0]             ISSUE_OPCODE,
  output idt_pkg::idt_fmt_t      ISSUE_FORMAT,
  output logic [1:0]             ISSUE_CYCLES,
  // Decoded operands
  output logic                   OP_BYTE,
  output logic [3:0]             OP_BASE_REG,
  output logic [3:0]             OP_SRC_REG,
  output logic [1:0]             OP_SRC_MODE,
  output logic [3:0]             OP_DST_REG,
  output logic [1:0]             OP_DST_MODE,
  output logic                   OP_DST_VALID,
  output logic [12:0]            OP_FILE_ADDR,
  output logic                   OP_DEST_FILE,
  output logic [3:0]             OP_BIT_POS,
  output logic                   OP_BIT_INDIRECT,
  output logic [15:0]            OP_LITERAL,
  output logic [22:0]            OP_PROG_ADDR,
  output logic [1:0]             OP_TBL_MODE
);
  import idt_pkg::*;

  // Decoded operand fields
  typedef struct packed {
    logic        byte_op;
    logic [3:0]  base_reg;
    logic [3:0]  src_reg;
    logic [1:0]  src_mode;
    logic [3:0]  dst_reg;
    logic [1:0]  dst_mode;
    logic        dst_valid;
    logic [12:0] file_addr;
    logic        dest_file;
    logic [3:0]  bit_pos;
    logic        bit_indirect;
    logic [15:0] literal;
    logic [22:0] prog_addr;
    logic [1:0]  tbl_mode;
  } idt_fields_t;

  // Whole module state
  typedef struct packed {
    idt_state_t  state;
    logic [1:0]  fill_cnt;
    logic        fill_hold;
    logic [23:0] first_word;
    idt_fmt_t    first_fmt;
    logic        redirect;
    logic        issue_valid;
    logic        issue_nop;
    logic [47:0] instr;
    idt_fmt_t    fmt;
    logic [1:0]  cycles;
    idt_fields_t fld;
  } idt_all_t;

  idt_all_t       state_reg;
  idt_all_t       state_next;

  idt_fmt_t       cls_fmt;
  idt_ctl_t       cls_ctl;
  logic           cls_dbl;
  logic [1:0]     cls_cycles;

  ////////////////////////////////////////////////////////////////////
  // Classification of the word on the fetch port
  idt_classify u_classify (
    .opcode (FETCH_WORD[`IDT_OPC_LSB +: 8]),
    .fmt    (cls_fmt),
    .ctl    (cls_ctl),
    .dbl    (cls_dbl),
    .cycles (cls_cycles)
  );

  ////////////////////////////////////////////////////////////////////
  // Operand extraction; w2 only matters for double-word forms
  function automatic idt_fields_t decode_fields(
    input logic [23:0] w1,
    input logic [23:0] w2,
    input logic        dw,
    input idt_fmt_t    fmt
  );
    idt_fields_t f;
    f = '0;
    f.byte_op = w1[`IDT_BYTE_BIT];
    case (fmt)
      FMT_WORK:
      begin
        f.base_reg  = w1[`IDT_BASE_LSB +: 4];
        f.src_mode  = w1[`IDT_SMODE_LSB +: 2];
        f.src_reg   = w1[`IDT_SREG_LSB +: 4];
        f.dst_mode  = w1[`IDT_DMODE_LSB +: 2];
        f.dst_reg   = w1[`IDT_DREG_LSB +: 4];
        f.dst_valid = 1'b1;
      end
      FMT_FILE:
      begin
        f.file_addr = w1[`IDT_FADDR_LSB +: 13];
        f.dest_file = w1[`IDT_FDEST_BIT];
        // Clear selector targets the working zero alias
        f.dst_reg   = 4'h0;
        f.dst_valid = ~w1[`IDT_FDEST_BIT];
      end
      FMT_BIT:
      begin
        f.bit_indirect = w1[`IDT_BIND_BIT];
        if (w1[`IDT_BIND_BIT])
          f.base_reg = w1[`IDT_BPOS_LSB +: 4];
        else
          f.bit_pos  = w1[`IDT_BPOS_LSB +: 4];
        if (w1[`IDT_BFILE_BIT])
          f.file_addr = {3'h0, w1[`IDT_BOPND_LSB +: 10]};
        else
        begin
          f.src_reg  = w1[`IDT_BOPND_LSB +: 4];
          f.src_mode = w1[`IDT_BOPND_LSB + 4 +: 2];
        end
      end
      FMT_LITMOV:
      begin
        // Double-word move carries a full literal in its second word
        if (dw)
          f.literal = w2[15:0];
        else
          f.literal = {4'h0, w1[`IDT_LMOV_LSB +: 12]};
        f.dst_reg   = w1[`IDT_DREG_LSB +: 4];
        f.dst_valid = 1'b1;
      end
      FMT_LITALU:
      begin
        f.base_reg = w1[`IDT_BASE_LSB +: 4];
        f.literal  = {11'h000, w1[`IDT_LALU_LSB +: 5]};
        // Destination only when it differs from the source
        if (!w1[`IDT_LSAME_BIT])
        begin
          f.dst_mode  = w1[`IDT_DMODE_LSB +: 2];
          f.dst_reg   = w1[`IDT_DREG_LSB +: 4];
          f.dst_valid = 1'b1;
        end
      end
      FMT_CTRL:
      begin
        if (dw)
          f.prog_addr = {w2[6:0], w1[15:0]};
        else
          f.prog_addr = {7'h00, w1[15:0]};
        f.tbl_mode = w1[`IDT_TMODE_LSB +: 2];
      end
      default:
      begin
        f.byte_op = 1'b0;
      end
    endcase
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Sequencer: issue, join, fill and discard
  always_comb
  begin
    state_next             = state_reg;
    state_next.redirect    = 1'b0;
    state_next.issue_valid = 1'b0;
    state_next.issue_nop   = 1'b0;
    case (state_reg.state)
      ST_RUN:
      begin
        if (FETCH_VALID)
        begin
          if (cls_dbl)
          begin
            // Hold the first half until its partner arrives
            state_next.first_word = FETCH_WORD;
            state_next.first_fmt  = cls_fmt;
            state_next.state      = ST_SECOND;
          end
          else
          begin
            state_next.issue_valid = 1'b1;
            state_next.issue_nop   = (FETCH_WORD[`IDT_OPC_LSB +: 8] == `IDT_OP_NOP);
            state_next.instr       = {FETCH_WORD, 24'h000000};
            state_next.fmt         = cls_fmt;
            state_next.fld         = decode_fields(FETCH_WORD, 24'h000000, 1'b0, cls_fmt);
            state_next.cycles      = cls_cycles;
            case (cls_ctl)
              CK_JUMP, CK_IND, CK_RET:
              begin
                state_next.redirect  = 1'b1;
                state_next.fill_cnt  = cls_cycles - 2'd1;
                state_next.fill_hold = 1'b0;
                state_next.state     = ST_FILL;
              end
              CK_TBL:
              begin
                // Table access stalls fetch; the next word is still wanted
                state_next.fill_cnt  = cls_cycles - 2'd1;
                state_next.fill_hold = 1'b1;
                state_next.state     = ST_FILL;
              end
              CK_COND:
              begin
                if (COND_TRUE)
                begin
                  state_next.redirect  = 1'b1;
                  state_next.cycles    = `IDT_CYC_COND;
                  state_next.fill_cnt  = `IDT_CYC_COND - 2'd1;
                  state_next.fill_hold = 1'b0;
                  state_next.state     = ST_FILL;
                end
              end
              CK_SKIP:
              begin
                if (COND_TRUE)
                begin
                  state_next.cycles = 2'd2;
                  state_next.state  = ST_SKIP;
                end
              end
              default:
              begin
                state_next.state = ST_RUN;
              end
            endcase
          end
        end
      end
      ST_SECOND:
      begin
        if (FETCH_VALID)
        begin
          // Second word is taken as operand data, not decoded alone
          state_next.issue_valid = 1'b1;
          state_next.instr       = {state_reg.first_word, FETCH_WORD};
          state_next.fmt         = state_reg.first_fmt;
          state_next.fld         = decode_fields(state_reg.first_word, FETCH_WORD, 1'b1,
                                                 state_reg.first_fmt);
          state_next.cycles      = `IDT_CYC_DW;
          state_next.state       = ST_RUN;
        end
      end
      ST_FILL:
      begin
        state_next.issue_valid = 1'b1;
        state_next.issue_nop   = 1'b1;
        state_next.instr       = '0;
        state_next.fmt         = FMT_NONE;
        state_next.fld         = '0;
        state_next.fill_cnt    = state_reg.fill_cnt - 2'd1;
        if (state_reg.fill_cnt == 2'd1)
          state_next.state = ST_RUN;
      end
      ST_SKIP, ST_SKIP2:
      begin
        if (FETCH_VALID)
        begin
          // Skipped word is consumed and shown as a no-op
          state_next.issue_valid = 1'b1;
          state_next.issue_nop   = 1'b1;
          state_next.instr       = '0;
          state_next.fmt         = FMT_NONE;
          state_next.fld         = '0;
          if (state_reg.state == ST_SKIP && cls_dbl)
            state_next.state = ST_SKIP2;
          else
            state_next.state = ST_RUN;
        end
      end
      default:
      begin
        state_next.state = ST_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_reg           <= '0;
      state_reg.state     <= ST_RUN;
      state_reg.fmt       <= FMT_NONE;
      state_reg.first_fmt <= FMT_NONE;
    end
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs; only the fetch handshake is combinational
  assign FETCH_READY     = !(state_reg.state == ST_FILL && (state_reg.fill_hold || !state_reg.redirect));
  assign REDIRECT        = state_reg.redirect;
  assign ISSUE_VALID     = state_reg.issue_valid;
  assign ISSUE_NOP       = state_reg.issue_nop;
  assign ISSUE_INSTR     = state_reg.instr;
  assign ISSUE_OPCODE    = state_reg.instr[47:40];
  assign ISSUE_FORMAT    = state_reg.fmt;
  assign ISSUE_CYCLES    = state_reg.cycles;
  assign OP_BYTE         = state_reg.fld.byte_op;
  assign OP_BASE_REG     = state_reg.fld.base_reg;
  assign OP_SRC_REG      = state_reg.fld.src_reg;
  assign OP_SRC_MODE     = state_reg.fld.src_mode;
  assign OP_DST_REG      = state_reg.fld.dst_reg;
  assign OP_DST_MODE     = state_reg.fld.dst_mode;
  assign OP_DST_VALID    = state_reg.fld.dst_valid;
  assign OP_FILE_ADDR    = state_reg.fld.file_addr;
  assign OP_DEST_FILE    = state_reg.fld.dest_file;
  assign OP_BIT_POS      = state_reg.fld.bit_pos;
  assign OP_BIT_INDIRECT = state_reg.fld.bit_indirect;
  assign OP_LITERAL      = state_reg.fld.literal;
  assign OP_PROG_ADDR    = state_reg.fld.prog_addr;
  assign OP_TBL_MODE     = state_reg.fld.tbl_mode;
endmodule
`default_nettype wire
